// ---- src/dbexp_pkg.sv ----
// Package with the constants of the daughterboard expansion decode block.
package dbexp_pkg;
	localparam int ADDR_W = 23;
	localparam int XADDR_W = 22;
	localparam int DATA_W = 16;
	localparam int XDATA_W = 32;
	localparam int PAGE_W = 5;
	localparam int FLAG_N = 4;
	localparam int SPORT_W = 6;
	localparam int PROG_SEL_BIT = 22;
	localparam int IO_SEL_BIT = 15;
	localparam int WIN_LOW_W = 15;
	localparam logic TARGET_SEL_RESET = 1'h1;
	localparam logic [4:0] PAGE_RESET = 5'h00;
	// Two inputs and two outputs by default; a one marks an output.
	localparam logic [3:0] FLAG_DIR_RESET = 4'hC;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_PAGE = 8'h04;
	localparam logic [7:0] REG_FLAG = 8'h08;
	localparam logic [7:0] REG_STAT = 8'h0C;
	localparam int CTRL_TARGET_BIT = 0;
	localparam int CTRL_HPI_BOOT_BIT = 1;
	localparam int CTRL_CARD_INT_BIT = 2;
	localparam int FLAG_DIR_LSB = 0;
	localparam int FLAG_OUT_LSB = 4;
endpackage

// ---- src/daughterboard_expansion_decode.sv ----
// Glue logic exposing the DSP memory bus and peripherals to a daughterboard.
// Behaviour
// - A program access reaches the card only while address bit 22 is high.
// - A data access goes to the card only while the target select is one.
// - An I/O access goes to the card only while address bit 15 is high.
// - The five-bit page field supplies upper card address bits for data/I/O.
// - The card data space enable is active only with target select and strobe.
// - Program accesses pass address bits 21 to 0; data/I/O pass bits 14 to 0; bit 22 is withheld.
// - The card data bus is 32 bits, DSP data forming the low half.
// - Read, output, memory strobe and write enables go to the card; ready comes back from it.
// - DSP serial ports 0 and 2 appear as card serial ports 0 and 1.
// - Card interrupt two reaches the DSP only when not used as boot indicator.
// - Each of the four flag lines has its own direction bit.
// - A DSP-driven interrupt goes to the card beside acknowledge and inputs.
// - After reset the target select is one.
// - On-board program memory is selected only while address bit 22 is low.
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none
module daughterboard_expansion_decode (
	// Clock, reset, enable.
	input wire logic SYS_CLK_I,
	input wire logic RESETN_I,
	input wire logic CE_I,
	// Register port.
	input wire logic [7:0] REG_ADDR_I,
	input wire logic [31:0] REG_WDATA_I,
	input wire logic REG_WR_I,
	input wire logic REG_RD_I,
	output logic [31:0] REG_RDATA_O,
	// DSP memory side, active-low strobes.
	input wire logic [22:0] DSP_ADDR_I,
	input wire logic DSP_PS_N_I,
	input wire logic DSP_DS_N_I,
	input wire logic DSP_IS_N_I,
	input wire logic DSP_MSTRB_N_I,
	input wire logic DSP_IOSTRB_N_I,
	input wire logic DSP_RW_I,
	input wire logic [15:0] DSP_DATA_I,
	output logic [15:0] DSP_DATA_O,
	output logic DSP_READY_O,
	// On-board memory selects.
	output logic BOARD_PROG_SEL_N_O,
	output logic BOARD_DATA_SEL_N_O,
	// Card memory side.
	output logic [21:0] CARD_ADDR_O,
	output logic [31:0] CARD_DATA_O,
	output logic [31:0] CARD_DATA_OE_N_O,
	input wire logic [31:0] CARD_DATA_I,
	output logic EXPANSION_DATA_SPACE_ENABLE_N_O,
	output logic EXPANSION_PROGRAM_SPACE_ENABLE_N_O,
	output logic EXPANSION_IO_SPACE_ENABLE_N_O,
	output logic EXPANSION_READ_ENABLE_N_O,
	output logic CARD_OUTPUT_ENABLE_N_O,
	output logic EXPANSION_MEMORY_STROBE_N_O,
	output logic CARD_WRITE_ENABLE_N_O,
	output logic EXPANSION_IO_STROBE_N_O,
	input wire logic CARD_READY_N_I,
	// Serial ports: DSP side and card side, six signals each.
	input wire logic [5:0] DSP_SPORT0_I,
	input wire logic [5:0] DSP_SPORT2_I,
	output logic [5:0] CARD_SPORT0_O,
	output logic [5:0] CARD_SPORT1_O,
	// Interrupts and peripheral signals.
	input wire logic [3:0] CARD_INT_N_I,
	output logic [3:0] DSP_INT_N_O,
	input wire logic DSP_INTERRUPT_ACKNOWLEDGE_N_I,
	output logic CARD_INTERRUPT_ACKNOWLEDGE_N_O,
	output logic BOARD_TO_CARD_INTERRUPT_N_O,
	input wire logic DSP_TIMER_OUTPUT_I,
	output logic CARD_TIMER_OUTPUT_O,
	input wire logic DSP_GENERAL_OUTPUT_FLAG_I,
	output logic CARD_GENERAL_OUTPUT_FLAG_O,
	input wire logic CARD_GENERAL_INPUT_FLAG_N_I,
	output logic DSP_GENERAL_INPUT_FLAG_N_O,
	// General-purpose flag pins, three signals each.
	input wire logic [3:0] FLAG_I,
	output logic [3:0] FLAG_O,
	output logic [3:0] FLAG_OE_N_O
);

	logic target_sel_reg, target_sel_next;
	logic hpi_boot_reg, hpi_boot_next;
	logic card_int_reg, card_int_next;
	logic [4:0] page_reg, page_next;
	logic [3:0] flag_dir_reg, flag_dir_next;
	logic [3:0] flag_out_reg, flag_out_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [3:0] flag_s1_reg, flag_s2_reg;
	logic rdy_s1_reg, rdy_s2_reg;
	logic prog_card, data_card, io_card, card_any;
	logic prog_board, data_board;
	logic read_cyc;

	// Register write decode.
	function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
		return a == r;
	endfunction

	always_comb begin
		target_sel_next = target_sel_reg;
		hpi_boot_next = hpi_boot_reg;
		card_int_next = card_int_reg;
		page_next = page_reg;
		flag_dir_next = flag_dir_reg;
		flag_out_next = flag_out_reg;
		rdata_next = 32'h00000000;
		if (REG_WR_I && hit(REG_ADDR_I, dbexp_pkg::REG_CTRL)) begin
			target_sel_next = REG_WDATA_I[dbexp_pkg::CTRL_TARGET_BIT];
			hpi_boot_next = REG_WDATA_I[dbexp_pkg::CTRL_HPI_BOOT_BIT];
			card_int_next = REG_WDATA_I[dbexp_pkg::CTRL_CARD_INT_BIT];
		end
		if (REG_WR_I && hit(REG_ADDR_I, dbexp_pkg::REG_PAGE)) begin
			page_next = REG_WDATA_I[4:0];
		end
		if (REG_WR_I && hit(REG_ADDR_I, dbexp_pkg::REG_FLAG)) begin
			flag_dir_next = REG_WDATA_I[dbexp_pkg::FLAG_DIR_LSB +: 4];
			flag_out_next = REG_WDATA_I[dbexp_pkg::FLAG_OUT_LSB +: 4];
		end
		if (REG_RD_I) begin
			case (REG_ADDR_I)
				dbexp_pkg::REG_CTRL: rdata_next = {29'h00000000,
					card_int_reg, hpi_boot_reg, target_sel_reg};
				dbexp_pkg::REG_PAGE: rdata_next = {27'h0000000, page_reg};
				dbexp_pkg::REG_FLAG: rdata_next = {24'h000000,
					flag_out_reg, flag_dir_reg};
				// Status shows the synchronised flag pins and card ready.
				dbexp_pkg::REG_STAT: rdata_next = {27'h0000000,
					~rdy_s2_reg, flag_s2_reg};
				default: rdata_next = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!RESETN_I) begin
			target_sel_reg <= dbexp_pkg::TARGET_SEL_RESET;
			hpi_boot_reg <= 1'h0;
			card_int_reg <= 1'h0;
			page_reg <= dbexp_pkg::PAGE_RESET;
			flag_dir_reg <= dbexp_pkg::FLAG_DIR_RESET;
			flag_out_reg <= 4'h0;
			rdata_reg <= 32'h00000000;
			flag_s1_reg <= 4'h0;
			flag_s2_reg <= 4'h0;
			rdy_s1_reg <= 1'h1;
			rdy_s2_reg <= 1'h1;
		end else if (CE_I) begin
			target_sel_reg <= target_sel_next;
			hpi_boot_reg <= hpi_boot_next;
			card_int_reg <= card_int_next;
			page_reg <= page_next;
			flag_dir_reg <= flag_dir_next;
			flag_out_reg <= flag_out_next;
			rdata_reg <= rdata_next;
			flag_s1_reg <= FLAG_I;
			flag_s2_reg <= flag_s1_reg;
			rdy_s1_reg <= CARD_READY_N_I;
			rdy_s2_reg <= rdy_s1_reg;
		end
	end

	assign REG_RDATA_O = rdata_reg;

	// Space decode; the strobes are asynchronous glue on the memory path.
	always_comb begin
		prog_card = !DSP_PS_N_I && DSP_ADDR_I[dbexp_pkg::PROG_SEL_BIT];
		prog_board = !DSP_PS_N_I && !DSP_ADDR_I[dbexp_pkg::PROG_SEL_BIT];
		data_card = !DSP_DS_N_I && target_sel_reg;
		data_board = !DSP_DS_N_I && !target_sel_reg;
		io_card = !DSP_IS_N_I && DSP_ADDR_I[dbexp_pkg::IO_SEL_BIT];
		card_any = prog_card || data_card || io_card;
		read_cyc = DSP_RW_I && card_any;
	end

	assign BOARD_PROG_SEL_N_O = !(prog_board && !card_any);
	assign BOARD_DATA_SEL_N_O = !(data_board && !card_any);
	assign EXPANSION_PROGRAM_SPACE_ENABLE_N_O = !prog_card;
	assign EXPANSION_DATA_SPACE_ENABLE_N_O = !data_card;
	assign EXPANSION_IO_SPACE_ENABLE_N_O = !io_card;

	// Data and I/O take the page as upper bits; program passes 21:0.
	always_comb begin
		if (!DSP_PS_N_I) begin
			CARD_ADDR_O = DSP_ADDR_I[21:0];
		end else begin
			CARD_ADDR_O = {2'h0, page_reg,
				DSP_ADDR_I[dbexp_pkg::WIN_LOW_W-1:0]};
		end
	end

	// Memory controls derived from the DSP strobes.
	assign EXPANSION_MEMORY_STROBE_N_O = DSP_MSTRB_N_I || !card_any;
	assign EXPANSION_IO_STROBE_N_O = DSP_IOSTRB_N_I || !io_card;
	assign EXPANSION_READ_ENABLE_N_O = !(read_cyc &&
		!(DSP_MSTRB_N_I && DSP_IOSTRB_N_I));
	assign CARD_OUTPUT_ENABLE_N_O = !read_cyc;
	assign CARD_WRITE_ENABLE_N_O = !(!DSP_RW_I && card_any &&
		!(DSP_MSTRB_N_I && DSP_IOSTRB_N_I));
	// The DSP waits while the card holds ready inactive.
	assign DSP_READY_O = !card_any || !rdy_s2_reg;

	assign CARD_DATA_O = {16'h0000, DSP_DATA_I};
	assign CARD_DATA_OE_N_O = {32{!(card_any && !DSP_RW_I)}};
	assign DSP_DATA_O = CARD_DATA_I[15:0];

	assign CARD_SPORT0_O = DSP_SPORT0_I;
	assign CARD_SPORT1_O = DSP_SPORT2_I;

	assign DSP_INT_N_O = {CARD_INT_N_I[3],
		CARD_INT_N_I[2] || hpi_boot_reg, CARD_INT_N_I[1:0]};
	assign CARD_INTERRUPT_ACKNOWLEDGE_N_O = DSP_INTERRUPT_ACKNOWLEDGE_N_I;
	assign BOARD_TO_CARD_INTERRUPT_N_O = !card_int_reg;
	assign CARD_TIMER_OUTPUT_O = DSP_TIMER_OUTPUT_I;
	assign CARD_GENERAL_OUTPUT_FLAG_O = DSP_GENERAL_OUTPUT_FLAG_I;
	assign DSP_GENERAL_INPUT_FLAG_N_O = CARD_GENERAL_INPUT_FLAG_N_I;

	genvar g;
	generate
		for (g = 0; g < dbexp_pkg::FLAG_N; g++) begin : g_flag
			assign FLAG_O[g] = flag_out_reg[g];
			assign FLAG_OE_N_O[g] = !flag_dir_reg[g];
		end
	endgenerate

	property p_excl;
		@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		!(!BOARD_DATA_SEL_N_O && !EXPANSION_DATA_SPACE_ENABLE_N_O);
	endproperty
	a_excl: assert property (p_excl) else $error("data selects overlap");

	property p_prog;
		@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		!BOARD_PROG_SEL_N_O |-> !DSP_ADDR_I[22] && !DSP_PS_N_I;
	endproperty
	a_prog: assert property (p_prog) else $error("board prog bad");

	property p_pcard;
		@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		!EXPANSION_PROGRAM_SPACE_ENABLE_N_O |-> DSP_ADDR_I[22];
	endproperty
	a_pcard: assert property (p_pcard) else $error("card prog bad");

	property p_ds;
		@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		!EXPANSION_DATA_SPACE_ENABLE_N_O |-> target_sel_reg && !DSP_DS_N_I;
	endproperty
	a_ds: assert property (p_ds) else $error("data enable bad");

	property p_io;
		@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		!EXPANSION_IO_SPACE_ENABLE_N_O |-> DSP_ADDR_I[15];
	endproperty
	a_io: assert property (p_io) else $error("io enable bad");

	property p_rst;
		@(posedge SYS_CLK_I) $rose(RESETN_I) |-> target_sel_reg;
	endproperty
	a_rst: assert property (p_rst) else $error("target not one");

	property p_page;
		@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		DSP_PS_N_I |-> CARD_ADDR_O[19:15] == page_reg;
	endproperty
	a_page: assert property (p_page) else $error("page bits bad");

	property p_external_interrupt_two;
		@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		hpi_boot_reg |-> DSP_INT_N_O[2];
	endproperty
	a_external_interrupt_two: assert property (p_external_interrupt_two) else $error("external_interrupt_two leaked");

	property p_rdy;
		@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		(card_any && rdy_s2_reg) |-> !DSP_READY_O;
	endproperty
	a_rdy: assert property (p_rdy) else $error("ready not held");

	// Two sampled edges of a busy card must reach the DSP as a wait.
	sequence s_card_busy;
		(CE_I && CARD_READY_N_I) ##1 (CE_I && CARD_READY_N_I);
	endsequence

	property p_stretch;
		@(posedge SYS_CLK_I) disable iff (!RESETN_I)
		s_card_busy ##1 card_any |-> !DSP_READY_O;
	endproperty
	a_stretch: assert property (p_stretch) else $error("access not held");

endmodule // daughterboard_expansion_decode
`default_nettype wire

// ---- bench/card_mem_model.sv ----
// Behavioural daughterboard memory that answers the card bus.
`timescale 1ns/100ps
`default_nettype none
module card_mem_model (
	// Clock and pace.
	input wire logic clk_i,
	input wire logic slow_i,
	// Card bus.
	input wire logic [21:0] addr_i,
	input wire logic [31:0] data_i,
	input wire logic sel_n_i,
	input wire logic oe_n_i,
	input wire logic we_n_i,
	output logic [31:0] data_o,
	output logic ready_n_o
);
	logic [31:0] mem [256];
	logic [31:0] last = 32'h0;
	int cnt = 0;
	always @(posedge clk_i) begin
		cnt <= sel_n_i ? 0 : cnt + 1;
		if (!we_n_i && !sel_n_i)
			mem[addr_i[7:0]] <= data_i;
		if (!oe_n_i)
			last <= mem[addr_i[7:0]];
	end
	// A slow card inserts four wait cycles into every access.
	assign ready_n_o = slow_i && (sel_n_i || cnt < 4);
	// A released bus shows the inverse of the last word, not a held value.
	assign data_o = oe_n_i ? ~last : mem[addr_i[7:0]];
endmodule // card_mem_model
`default_nettype wire

// ---- bench/daughterboard_expansion_decode_bench.sv ----
// Self-checking bench of the daughterboard expansion decode block.
`timescale 1ns/100ps
`default_nettype none
module daughterboard_expansion_decode_bench;
	logic clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, rw = 1'b1;
	logic ps_n = 1'b1, ds_n = 1'b1, is_n = 1'b1, ms_n = 1'b1, io_n = 1'b1;
	logic slow = 1'b0, ack = 1'b1, timer_output = 1'b0, xf = 1'b0, general_input_flag = 1'b1;
	logic ce = 1'b1;
	logic [7:0] ra = 8'h00;
	logic [31:0] wd = 32'h0, rdata, cdo, cdoe, cdi;
	logic [22:0] da = 23'h0;
	logic [15:0] dd = 16'h0, dout;
	logic [21:0] caddr;
	logic [5:0] sp0 = 6'h00, sp2 = 6'h00, csp0, csp1;
	logic [3:0] cint = 4'hF, fi = 4'h0, dint, fo, foe;
	logic rdy, bp_n, bd_n, xds, xps, xis, xre, xoe, xms, xwe, xio, crdy;
	logic cack, b2c, ctout, cxf, dbio, tgt;
	logic [4:0] pg;
	int err_count = 0, num_checks = 0, seed = 30389;
	always #2.5 clk = ~clk;
	daughterboard_expansion_decode u_dut (.SYS_CLK_I(clk), .RESETN_I(rstn),
		.CE_I(ce), .REG_ADDR_I(ra), .REG_WDATA_I(wd), .REG_WR_I(wr),
		.REG_RD_I(rd), .REG_RDATA_O(rdata), .DSP_ADDR_I(da), .DSP_PS_N_I(ps_n),
		.DSP_DS_N_I(ds_n), .DSP_IS_N_I(is_n), .DSP_MSTRB_N_I(ms_n),
		.DSP_IOSTRB_N_I(io_n), .DSP_RW_I(rw), .DSP_DATA_I(dd),
		.DSP_DATA_O(dout), .DSP_READY_O(rdy), .BOARD_PROG_SEL_N_O(bp_n),
		.BOARD_DATA_SEL_N_O(bd_n), .CARD_ADDR_O(caddr), .CARD_DATA_O(cdo),
		.CARD_DATA_OE_N_O(cdoe), .CARD_DATA_I(cdi),
		.EXPANSION_DATA_SPACE_ENABLE_N_O(xds),
		.EXPANSION_PROGRAM_SPACE_ENABLE_N_O(xps),
		.EXPANSION_IO_SPACE_ENABLE_N_O(xis), .EXPANSION_READ_ENABLE_N_O(xre),
		.CARD_OUTPUT_ENABLE_N_O(xoe), .EXPANSION_MEMORY_STROBE_N_O(xms),
		.CARD_WRITE_ENABLE_N_O(xwe), .EXPANSION_IO_STROBE_N_O(xio),
		.CARD_READY_N_I(crdy), .DSP_SPORT0_I(sp0), .DSP_SPORT2_I(sp2),
		.CARD_SPORT0_O(csp0), .CARD_SPORT1_O(csp1), .CARD_INT_N_I(cint),
		.DSP_INT_N_O(dint), .DSP_INTERRUPT_ACKNOWLEDGE_N_I(ack),
		.CARD_INTERRUPT_ACKNOWLEDGE_N_O(cack),
		.BOARD_TO_CARD_INTERRUPT_N_O(b2c), .DSP_TIMER_OUTPUT_I(timer_output),
		.CARD_TIMER_OUTPUT_O(ctout), .DSP_GENERAL_OUTPUT_FLAG_I(xf),
		.CARD_GENERAL_OUTPUT_FLAG_O(cxf), .CARD_GENERAL_INPUT_FLAG_N_I(general_input_flag),
		.DSP_GENERAL_INPUT_FLAG_N_O(dbio), .FLAG_I(fi), .FLAG_O(fo),
		.FLAG_OE_N_O(foe));
	card_mem_model u_card (.clk_i(clk), .slow_i(slow), .addr_i(caddr),
		.data_i(cdo), .sel_n_i(xps && xds && xis), .oe_n_i(xoe),
		.we_n_i(xwe), .data_o(cdi), .ready_n_o(crdy));
	task automatic chk(input string n, input logic [63:0] s, e);
		num_checks++;
		if (s !== e) begin
			err_count++;
			$display("unexpected %s exp %h seen %h", n, e, s);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		ra <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		ra <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	function automatic logic [28:0] dec(input int s, input logic [22:0] a,
		input logic r);
		logic c;
		c = s == 0 ? a[22] : (s == 1 ? tgt : a[15]);
		dec = {!(c && s == 0), !(c && s == 1), !(c && s == 2),
			s == 0 ? a[22] : 1'b1, s == 1 ? tgt : 1'b1,
			s == 0 ? a[21:0] : {2'h0, pg, a[14:0]}, !(c && r), !(c && !r)};
	endfunction
	task automatic acc(input int s, input logic [22:0] a, input logic r,
		input logic [15:0] d, output logic [15:0] q);
		logic c;
		c = s == 0 ? a[22] : (s == 1 ? tgt : a[15]);
		@(posedge clk);
		da <= a;
		rw <= r;
		dd <= d;
		{ps_n, ds_n, is_n} <= ~(3'h4 >> s);
		ms_n <= s == 2;
		io_n <= s != 2;
		@(posedge clk);
		#1 chk("wait", rdy, !slow);
		chk("decode", {xps, xds, xis, bp_n, bd_n, caddr, xoe, xwe},
			dec(s, a, r));
		chk("wdata", cdo, {16'h0, d});
		chk("strobes", {xre, xms, xio, cdoe}, {!(c && r), s == 2 || !c,
			s != 2 || !c, {32{!(c && !r)}}});
		for (int n = 0; n < 20 && rdy !== 1'b1; n++)
			@(posedge clk) #1;
		chk("ready", rdy, 1'b1);
		q = dout;
		@(posedge clk);
		{ps_n, ds_n, is_n, ms_n, io_n} <= 5'h1F;
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		#50000;
		err_count++;
		give_verdict();
	end
	initial begin
		logic [31:0] v, c;
		logic [15:0] q, d;
		logic [22:0] a;
		int s;
		repeat (6) @(posedge clk);
		rstn <= 1'b1;
		rreg(8'h00, v);
		chk("ctrl", v, 32'h1);
		rreg(8'h08, v);
		chk("flag", v, 32'hC);
		rreg(8'h10, v);
		chk("unmapped", v, 32'h0);
		chk("flag_oe", foe, 4'h3);
		$display("reset test done");
		for (int i = 0; i < 40; i++) begin
			c = $random(seed);
			tgt = c[0];
			pg = c[8:4];
			v = $random(seed);
			{sp0, sp2, cint, fi, ack, timer_output, xf, general_input_flag} <= v[23:0];
			wreg(8'h00, {29'h0, c[2:0]});
			wreg(8'h04, {27'h0, pg});
			wreg(8'h08, {24'h0, c[19:12]});
			s = (c[31:24] & 8'h7F) % 3;
			v = $random(seed);
			a = v[22:0];
			a[15] = a[15] || s == 1;
			acc(s, a, c[20], c[15:0], q);
			chk("flag_pins", {foe, fo}, {~c[15:12], c[19:16]});
			chk("wires", {csp0, csp1, cack, ctout, cxf, dbio},
				{sp0, sp2, ack, timer_output, xf, general_input_flag});
			chk("ints", {dint, b2c},
				{cint[3], cint[2] || c[1], cint[1:0], !c[2]});
			rreg(8'h0C, v);
			chk("stat", v, {27'h0, 1'b1, fi});
		end
		// A write while the enable is low must leave the page untouched.
		ce <= 1'b0;
		wreg(8'h04, {27'h0, ~pg});
		ce <= 1'b1;
		rreg(8'h04, v);
		chk("frozen_page", v, {27'h0, pg});
		$display("decode test done");
		tgt = 1'b1;
		wreg(8'h00, 32'h1);
		for (s = 0; s < 2; s++) begin
			v = $random(seed);
			d = v[15:0];
			a = {1'b1, 6'h00, 1'b1, 7'h00, d[7:0]};
			acc(s, a, 1'b0, d, q);
			slow <= 1'b1;
			acc(s, a, 1'b1, 16'h0, q);
			slow <= 1'b0;
			chk("readback", q, d);
		end
		$display("data test done");
		give_verdict();
	end
endmodule // daughterboard_expansion_decode_bench
`default_nettype wire
